// File: include/odu_pkg.sv
// Constants for the octal converter update command decoder
// Behaviour
// RL1 - Select-for-update command with address 0..7 marks that channel; data ignored.
// RL2 - Address with top bit set, except all ones, is invalid and does nothing.
// RL3 - Select-for-update with address all ones marks all eight channels.
// RL4 - Write-update-own loads one input register and updates that output only.
// RL5 - Write-update-own broadcast loads all inputs and updates all outputs.
// RL6 - Write-update-all loads addressed input then updates every output from inputs.
// RL7 - Twelve bits: first byte bits 11..4, second byte upper nibble bits 3..0.
// RL8 - Ten bits: first byte bits 9..2, second byte top two bits 1..0.
// RL9 - Eight bits: first byte holds the code; second byte fully ignored.
// RL10 - Write-update-all with address 7 loads channel H and updates all outputs.
// RL11 - Write-update-all broadcast loads all inputs and updates all outputs.
// RL12 - Outputs change only on update; plain loads and invalid codes leave them.
package odu_pkg;
  localparam int ODU_CHANNELS = 8;
  localparam logic [3:0] ODU_CMD_SELECT = 4'h1;
  localparam logic [3:0] ODU_CMD_WR_ALL = 4'h2;
  localparam logic [3:0] ODU_CMD_WR_OWN = 4'h3;
  localparam logic [3:0] ODU_ADDR_BCAST = 4'hf;
  localparam int ODU_CMD_POS = 4;
  localparam logic [7:0] ODU_RESET_MARK = 8'h00;
endpackage

// File: src/odu_decoder.sv
// Octal converter update command decoder
`timescale 1ns/1ps
`default_nettype none
module odu_decoder
  import odu_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command frame from the serial front end
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [7:0] msdb,
  input wire logic [7:0] lsdb,
  // Per-channel state and update strobe
  output logic [ODU_CHANNELS*RES_BITS-1:0] input_regs,
  output logic [ODU_CHANNELS*RES_BITS-1:0] output_regs,
  output logic [ODU_CHANNELS-1:0] update_marks,
  output logic load_output_strobe
);
  // Channel registers
  logic [RES_BITS-1:0] in_q [ODU_CHANNELS];
  logic [RES_BITS-1:0] in_d [ODU_CHANNELS];
  logic [RES_BITS-1:0] out_q [ODU_CHANNELS];
  logic [RES_BITS-1:0] out_d [ODU_CHANNELS];

  // Marks and strobe
  logic [ODU_CHANNELS-1:0] mark_q;
  logic [ODU_CHANNELS-1:0] mark_d;
  logic strobe_q;
  logic strobe_d;

  // Decoded frame
  logic [3:0] command_code;
  logic [3:0] access_address;
  logic [RES_BITS-1:0] code;
  logic bcast;
  logic single;
  logic invalid;
  logic wr_cmd;
  logic [ODU_CHANNELS-1:0] chan_sel;
  logic [ODU_CHANNELS-1:0] load_sel;
  logic [ODU_CHANNELS-1:0] upd_sel;

  // One-hot channel select from the low address bits
  function automatic logic [ODU_CHANNELS-1:0] chan_onehot(input logic [2:0] addr);
    logic [ODU_CHANNELS-1:0] sel;
    sel = '0;
    sel[addr] = 1'b1;
    return sel;
  endfunction

  // Code taken from the two data bytes for this resolution
  function automatic logic [RES_BITS-1:0] align_code(input logic [7:0] hi,
    input logic [7:0] lo);
    logic [RES_BITS-1:0] res;
    res = '0;
    if (RES_BITS == 12) begin
      res = RES_BITS'({hi, lo[7:4]}); // [RL7]
    end else if (RES_BITS == 10) begin
      res = RES_BITS'({hi, lo[7:6]}); // [RL8]
    end else begin
      res = RES_BITS'(hi); // [RL9]
    end
    return res;
  endfunction

  // Field split of the command byte
  assign command_code = cmd_byte[7:ODU_CMD_POS];
  assign access_address = cmd_byte[ODU_CMD_POS-1:0];
  assign bcast = (access_address == ODU_ADDR_BCAST); // [RL3] [RL5] [RL11]
  assign single = ~access_address[3];
  assign invalid = access_address[3] && !bcast; // [RL2]
  assign wr_cmd = (command_code == ODU_CMD_WR_OWN) || (command_code == ODU_CMD_WR_ALL);
  assign chan_sel = chan_onehot(access_address[2:0]);
  assign code = align_code(msdb, lsdb); // [RL7] [RL8] [RL9]

  // Command decode
  always_comb begin
    load_sel = '0;
    upd_sel = '0;
    mark_d = mark_q;
    if (cmd_valid && !invalid) begin // [RL2]
      case (command_code)
        ODU_CMD_SELECT: begin
          if (bcast) begin
            mark_d = '1; // [RL3]
          end else begin
            mark_d = mark_q | chan_sel; // [RL1]
          end
        end
        ODU_CMD_WR_OWN: begin
          if (bcast) begin
            load_sel = '1; // [RL5]
            upd_sel = '1; // [RL5]
          end else begin
            load_sel = chan_sel; // [RL4]
            upd_sel = chan_sel; // [RL4]
          end
        end
        ODU_CMD_WR_ALL: begin
          if (bcast) begin
            load_sel = '1; // [RL11]
          end else begin
            load_sel = chan_sel; // [RL6] [RL10]
          end
          upd_sel = '1; // [RL6] [RL11]
        end
        default: begin
          load_sel = '0;
        end
      endcase
    end
    strobe_d = |upd_sel;
  end

  // Channel next values; updates copy the freshly loaded input value
  always_comb begin
    for (int i = 0; i < ODU_CHANNELS; i++) begin
      in_d[i] = load_sel[i] ? code : in_q[i];
      out_d[i] = upd_sel[i] ? in_d[i] : out_q[i]; // [RL12]
    end
  end

  // Channel registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < ODU_CHANNELS; i++) begin
        in_q[i] <= '0;
        out_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < ODU_CHANNELS; i++) begin
        in_q[i] <= in_d[i];
        out_q[i] <= out_d[i];
      end
    end
  end

  // Flattened channel outputs
  for (genvar g = 0; g < ODU_CHANNELS; g++) begin : g_ch
    assign input_regs[g*RES_BITS +: RES_BITS] = in_q[g];
    assign output_regs[g*RES_BITS +: RES_BITS] = out_q[g];
  end

  // Marks and strobe registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mark_q <= ODU_RESET_MARK;
      strobe_q <= 1'b0;
    end else begin
      mark_q <= mark_d;
      strobe_q <= strobe_d;
    end
  end

  assign update_marks = mark_q;
  assign load_output_strobe = strobe_q;

  // Assertions
  a_invalid_no_change: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
    (cmd_valid && wr_cmd && invalid)
      |=> $stable(output_regs) && $stable(input_regs))
    else $error("invalid address changed registers");

  a_select_invalid: assert property (@(posedge clk) disable iff (!nrst) // [RL2]
    (cmd_valid && command_code == ODU_CMD_SELECT && invalid)
      |=> $stable(update_marks))
    else $error("invalid select changed marks");

  a_select_marks: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
    (cmd_valid && command_code == ODU_CMD_SELECT && single)
      |=> update_marks[$past(access_address[2:0])] && $stable(output_regs))
    else $error("select did not mark channel");

  a_select_bcast: assert property (@(posedge clk) disable iff (!nrst) // [RL3]
    (cmd_valid && command_code == ODU_CMD_SELECT && bcast)
      |=> update_marks == 8'hff)
    else $error("broadcast select missed channels");

  a_own_update: assert property (@(posedge clk) disable iff (!nrst) // [RL4]
    (cmd_valid && command_code == ODU_CMD_WR_OWN && single && access_address[2:0] == 3'h0)
      |=> out_q[0] == $past(code) && $stable(output_regs[ODU_CHANNELS*RES_BITS-1:RES_BITS]))
    else $error("own update wrong");

  a_bcast_write: assert property (@(posedge clk) disable iff (!nrst) // [RL5] [RL11]
    (cmd_valid && wr_cmd && bcast)
      |=> out_q[7] == $past(code) && in_q[3] == $past(code))
    else $error("broadcast write wrong");

  a_all_update: assert property (@(posedge clk) disable iff (!nrst) // [RL6] [RL10]
    (cmd_valid && command_code == ODU_CMD_WR_ALL && single && access_address[2:0] == 3'h7)
      |=> out_q[7] == $past(code) && out_q[0] == $past(in_q[0]))
    else $error("update all wrong");

  a_strobe_on_write: assert property (@(posedge clk) disable iff (!nrst) // [RL6]
    (cmd_valid && wr_cmd && !invalid)
      |=> load_output_strobe)
    else $error("write without strobe");

  a_align_code: assert property (@(posedge clk) disable iff (!nrst) // [RL7]
    (RES_BITS == 12) |-> code[RES_BITS-1 -: 8] == msdb && code[3:0] == lsdb[7:4])
    else $error("twelve bit alignment wrong");

  a_align_ten: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
    (RES_BITS == 10) |-> code[RES_BITS-1 -: 8] == msdb && code[1:0] == lsdb[7:6])
    else $error("ten bit alignment wrong");

  a_align_eight: assert property (@(posedge clk) disable iff (!nrst) // [RL9]
    (RES_BITS == 8) |-> code[RES_BITS-1 -: 8] == msdb)
    else $error("eight bit alignment wrong");

  a_out_only_update: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
    !$past(cmd_valid && wr_cmd) |-> $stable(output_regs))
    else $error("output changed without update");

  a_strobe_pulse: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
    load_output_strobe |-> $past(cmd_valid && wr_cmd))
    else $error("stray strobe");

  // Main scenarios
  c_select: cover property (@(posedge clk) cmd_valid && command_code == ODU_CMD_SELECT);

  c_select_bcast: cover property (@(posedge clk)
    cmd_valid && command_code == ODU_CMD_SELECT && bcast);

  c_own: cover property (@(posedge clk) cmd_valid && command_code == ODU_CMD_WR_OWN && single);

  c_all: cover property (@(posedge clk) cmd_valid && command_code == ODU_CMD_WR_ALL && bcast);

  c_invalid: cover property (@(posedge clk) cmd_valid && wr_cmd && invalid);
endmodule
`default_nettype wire

// File: testbench/odu_master.sv
// Bus master model that hands whole command frames to the decoder
`timescale 1ns/1ps
`default_nettype none
module odu_master (
  // Clock
  input wire logic clk,
  // Frame towards the decoder
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic [7:0] msdb,
  output logic [7:0] lsdb
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    msdb = 8'h00;
    lsdb = 8'h00;
  end
  // One frame, one cycle, then stale bytes inverted
  task automatic send(input logic [7:0] c, input logic [7:0] m, input logic [7:0] l);
    @(negedge clk);
    cmd_valid = 1'b1;
    {cmd_byte, msdb, lsdb} = {c, m, l};
    @(negedge clk);
    cmd_valid = 1'b0;
    {cmd_byte, msdb, lsdb} = ~{c, m, l};
  endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the update command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import odu_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cv, st, st_m;
  logic [7:0] cb, ms, ls, mk, mk_m, c;
  logic [95:0] ir, orr;
  logic [11:0] in_m [8];
  logic [11:0] out_m [8];
  int fail_count = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  odu_master mst (.clk(clk), .cmd_valid(cv), .cmd_byte(cb), .msdb(ms), .lsdb(ls));
  odu_decoder #(.RES_BITS(12)) uut (.clk(clk), .nrst(nrst), .cmd_valid(cv), .cmd_byte(cb),
    .msdb(ms), .lsdb(ls), .input_regs(ir), .output_regs(orr), .update_marks(mk),
    .load_output_strobe(st));
  function automatic logic [95:0] pk(input logic [11:0] a [8]);
    for (int i = 0; i < 8; i++) pk[i*12 +: 12] = a[i];
  endfunction
  task automatic chk(input string n, input logic [95:0] s, input logic [95:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input logic [7:0] cmd);
    logic [7:0] m, l;
    logic [11:0] d;
    m = 8'($urandom);
    l = 8'($urandom);
    mst.send(cmd, m, l);
    d = {m, l[7:4]};
    st_m = 1'b0;
    if (!(cmd[3] && cmd[3:0] != ODU_ADDR_BCAST)) begin
      for (int i = 0; i < 8; i++) begin
        if (cmd[3:0] == i || cmd[3]) begin
          if (cmd[7:4] == ODU_CMD_SELECT) mk_m[i] = 1'b1;
          if (cmd[7:4] == ODU_CMD_WR_ALL) in_m[i] = d;
          if (cmd[7:4] == ODU_CMD_WR_OWN) begin
            in_m[i] = d;
            out_m[i] = d;
            st_m = 1'b1;
          end
        end
      end
      if (cmd[7:4] == ODU_CMD_WR_ALL) begin
        out_m = in_m;
        st_m = 1'b1;
      end
    end
    chk("input_regs", ir, pk(in_m));
    chk("output_regs", orr, pk(out_m));
    chk("update_marks", mk, mk_m);
    chk("strobe", st, st_m);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(96232));
    foreach (in_m[i]) {in_m[i], out_m[i]} = 24'h000000;
    mk_m = ODU_RESET_MARK;
    repeat (2) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    step(8'h3f);
    step(8'h18);
    step(8'h2f);
    step(8'h27);
    step(8'h1f);
    step(8'h38);
    $display("corner frames done");
    repeat (300) begin
      c = 8'($urandom);
      step({1'b0, c[6:0]});
    end
    $display("random frames done");
    results;
  end
  initial begin
    #200000;
    fail_count++;
    results;
  end
endmodule
`default_nettype wire
